// File: verilog/ladder_boolean_evaluator.sv
`timescale 1ns/1ns
// Operation
// - Load contact starts a new branch equal to the addressed point.
// - Inverted load starts a branch with the complement of the point.
// - Word-bit variants pick one BCD-indexed bit, 0 to 15, of a word.
// - Parallel contact ORs the rung result with the point.
// - Inverted parallel contact ORs the rung result with the complement.
// - Series contact ANDs the rung result with the point.
// - Inverted series contact ANDs the rung result with the complement.
// - Series branch combine ANDs the two newest branch results.
// - Parallel branch combine ORs the two newest branch results.
// - Output writes the current rung result to the addressed location.
// - Repeated outputs to one location: the last executed one wins.
// - Eight-level boolean stack; deeper rungs are rejected with an error.
// - Loads push on top and move older entries down one level.
module ladder_boolean_evaluator (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic scan_start,
  input wire logic instr_valid,
  input wire ladder_pkg::instr_t instr,
  output logic instr_ready,
  output ladder_pkg::instr_t operand_req,
  input wire logic point_state,
  input wire logic [ladder_pkg::WORD_W-1:0] word_data,
  output logic out_we,
  output logic [ladder_pkg::ADDR_W-1:0] out_addr,
  output logic out_word_mode,
  output logic [ladder_pkg::BIT_W-1:0] out_bit,
  output logic out_value,
  output logic fault_valid,
  output ladder_pkg::fault_t fault,
  output logic [ladder_pkg::DEPTH_W-1:0] stack_depth,
  output logic rung_result
);

  // ************************************************************
  // Decode
  // ************************************************************
  // Operands are looked up combinationally from the image this cycle,
  // so the instruction's address goes straight out to the image memory.
  // The image answers in the same cycle, so ready never drops;
  // a slower image would need a wait state here.
  ladder_pkg::opcode_t op;
  assign op = instr.op;
  assign operand_req = instr;
  assign instr_ready = 1'b1;

  // Opcode classes, one named wire per family
  wire logic is_load = (op == ladder_pkg::OP_LOAD_CONTACT) ||
    (op == ladder_pkg::OP_LOAD_INVERTED_CONTACT) ||
    (op == ladder_pkg::OP_LOAD_WORD_BIT) ||
    (op == ladder_pkg::OP_LOAD_INVERTED_WORD_BIT);
  wire logic is_par = (op == ladder_pkg::OP_PARALLEL_CONTACT) ||
    (op == ladder_pkg::OP_PARALLEL_INVERTED_CONTACT) ||
    (op == ladder_pkg::OP_PARALLEL_WORD_BIT) ||
    (op == ladder_pkg::OP_PARALLEL_INVERTED_WORD_BIT);
  wire logic is_ser = (op == ladder_pkg::OP_SERIES_CONTACT) ||
    (op == ladder_pkg::OP_SERIES_INVERTED_CONTACT) ||
    (op == ladder_pkg::OP_SERIES_WORD_BIT) ||
    (op == ladder_pkg::OP_SERIES_INVERTED_WORD_BIT);
  wire logic is_comb = (op == ladder_pkg::OP_SERIES_BRANCH_COMBINE) ||
    (op == ladder_pkg::OP_PARALLEL_BRANCH_COMBINE);
  // The output instruction, kept apart from the contact families
  wire logic is_out = (op == ladder_pkg::OP_OUT);
  // Word-bit variants read one bit of word_data instead of point_state
  wire logic word_mode = (op == ladder_pkg::OP_LOAD_WORD_BIT) ||
    (op == ladder_pkg::OP_LOAD_INVERTED_WORD_BIT) ||
    (op == ladder_pkg::OP_PARALLEL_WORD_BIT) ||
    (op == ladder_pkg::OP_PARALLEL_INVERTED_WORD_BIT) ||
    (op == ladder_pkg::OP_SERIES_WORD_BIT) ||
    (op == ladder_pkg::OP_SERIES_INVERTED_WORD_BIT);
  // Normally closed variants
  wire logic invert = (op == ladder_pkg::OP_LOAD_INVERTED_CONTACT) ||
    (op == ladder_pkg::OP_LOAD_INVERTED_WORD_BIT) ||
    (op == ladder_pkg::OP_PARALLEL_INVERTED_CONTACT) ||
    (op == ladder_pkg::OP_PARALLEL_INVERTED_WORD_BIT) ||
    (op == ladder_pkg::OP_SERIES_INVERTED_CONTACT) ||
    (op == ladder_pkg::OP_SERIES_INVERTED_WORD_BIT);

  // ************************************************************
  // Contact value
  // ************************************************************
  // Contact state after inversion, and the bit-index error
  logic contact;
  logic bit_bad;

  // BCD decode and inversion live in the fetch block
  contact_fetch u_fetch (
    .word_mode(word_mode),
    .point_state(point_state),
    .word_data(word_data),
    .bit_bcd(instr.bit_bcd),
    .invert(invert),
    .contact(contact),
    .bit_bad(bit_bad)
  );

  // ************************************************************
  // Boolean stack
  // ************************************************************
  // Entry 0 is the top; depth counts live entries
  // Levels below the depth hold zero, so a combine shifts a clean zero in
  logic [ladder_pkg::STACK_DEPTH-1:0] stack_q;
  logic [ladder_pkg::STACK_DEPTH-1:0] stack_d;
  logic [ladder_pkg::DEPTH_W-1:0] depth_q;
  logic [ladder_pkg::DEPTH_W-1:0] depth_d;

  // Error checks: a rejected instruction leaves the stack untouched.
  // Overflow guards the eight levels; underflow means the program did not
  // open enough branches first, which would otherwise read empty levels that hold zero.
  wire logic ovf = is_load && (depth_q == ladder_pkg::DEPTH_FULL);
  wire logic unf_one = (is_par || is_ser || is_out) && (depth_q == ladder_pkg::DEPTH_ZERO);
  wire logic unf_two = is_comb && (depth_q < ladder_pkg::DEPTH_TWO);
  wire logic bad = bit_bad && (is_load || is_par || is_ser);
  // Scan start wins: an instruction in that cycle changes nothing at all
  wire logic take = instr_valid && !scan_start;
  wire logic fire = take && !ovf && !unf_one && !unf_two && !bad;
  wire logic do_load = fire && is_load;
  wire logic do_par = fire && is_par;
  wire logic do_ser = fire && is_ser;
  wire logic do_comb = fire && is_comb;

  // Combine value from the two newest entries
  wire logic comb_val = (op == ladder_pkg::OP_SERIES_BRANCH_COMBINE) ?
    (stack_q[0] & stack_q[1]) :
    (stack_q[0] | stack_q[1]);

  // Per-level next value: push shifts down, combine shifts up
  genvar g;
  generate
    for (g = 0; g < ladder_pkg::STACK_DEPTH; g++) begin : g_lvl
      wire logic below = (g + 1 < ladder_pkg::STACK_DEPTH) ?
        stack_q[(g + 1) % ladder_pkg::STACK_DEPTH] : 1'b0;
      wire logic above = (g > 0) ? stack_q[(g + ladder_pkg::STACK_DEPTH - 1) %
        ladder_pkg::STACK_DEPTH] : 1'b0;
      // Level 0 takes the new contact or the combined value
      if (g == 0) begin : g_top
        assign stack_d[g] = do_load ? contact :
          do_par ? (stack_q[0] | contact) :
          do_ser ? (stack_q[0] & contact) :
          do_comb ? comb_val : stack_q[0];
      end else if (g == 1) begin : g_second
        assign stack_d[g] = do_load ? above : do_comb ? below : stack_q[g];
      end else begin : g_rest
        // Deeper levels only shift with the stack
        assign stack_d[g] = do_load ? above : do_comb ? below : stack_q[g];
      end
    end
  endgenerate

  // Depth bookkeeping
  // Depth never passes eight because an overflowing load is refused
  assign depth_d = do_load ? 4'(depth_q + ladder_pkg::DEPTH_ONE) :
    do_comb ? 4'(depth_q - ladder_pkg::DEPTH_ONE) : depth_q;

  // Scan start empties the stack for a fresh program pass
  // Reset and scan start share one clear; scan start wins over any
  // instruction presented in the same cycle.
  always_ff @(posedge clk_sys) begin
    if (!reset_n || scan_start) begin
      stack_q <= '0;
      depth_q <= ladder_pkg::DEPTH_ZERO;
    end else if (instr_valid) begin
      stack_q <= stack_d;
      depth_q <= depth_d;
    end
  end

  // ************************************************************
  // Output writes and faults
  // ************************************************************
  // Each write goes out in program order, so the last one to a place wins
  // Writes are not filtered by address: duplicates all go out in order.
  // A bit write is chosen by a nonzero index, so bit 0 of a word cannot
  // be targeted by an output; plain point writes use index 00.
  wire logic do_out = fire && is_out;
  // Binary bit index for a bit write; only the low bit of the tens digit counts, worth ten.
  // An index over 15 is not refused here and simply wraps.
  wire logic [ladder_pkg::BIT_W-1:0] out_bit_d = 4'(instr.bit_bcd[3:0] +
    (instr.bit_bcd[4] ? ladder_pkg::BCD_TEN : 4'h0));

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      out_we <= 1'b0;
      out_addr <= '0;
      out_word_mode <= 1'b0;
      out_bit <= '0;
      out_value <= 1'b0;
    end else begin
      out_we <= do_out && !scan_start;
      if (do_out) begin
        out_addr <= instr.addr;
        out_word_mode <= instr.bit_bcd != '0;
        out_bit <= out_bit_d;
        out_value <= stack_q[0];
      end
    end
  end

  // Fault pulse for one cycle per rejected instruction
  // Fields refresh every cycle and mean something only with fault_valid
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      fault_valid <= 1'b0;
      fault <= '0;
    end else begin
      fault_valid <= instr_valid && !fire && !scan_start;
      fault.overflow <= ovf;
      fault.underflow <= unf_one || unf_two;
      fault.bad_bit <= bad;
    end
  end

  // Status for the program sequencer
  assign stack_depth = depth_q;
  assign rung_result = stack_q[0];

endmodule : ladder_boolean_evaluator

// File: verilog/ladder_pkg.sv
package ladder_pkg;

  // ************************************************************
  // Geometry of the evaluator
  // ************************************************************
  localparam int STACK_DEPTH = 8;
  localparam int DEPTH_W = 4;
  localparam int ADDR_W = 12;
  localparam int WORD_W = 16;
  localparam int BIT_W = 4;
  localparam int BCD_W = 8;
  localparam logic [DEPTH_W-1:0] DEPTH_ZERO = 4'h0;
  localparam logic [DEPTH_W-1:0] DEPTH_ONE = 4'h1;
  localparam logic [DEPTH_W-1:0] DEPTH_TWO = 4'h2;
  localparam logic [DEPTH_W-1:0] DEPTH_FULL = 4'h8;
  localparam logic [3:0] BCD_TEN = 4'hA;
  localparam logic [BIT_W-1:0] BIT_MAX = 4'hF;

  // ************************************************************
  // Instruction set
  // ************************************************************
  typedef enum logic [3:0] {
    OP_NOP,
    OP_LOAD_CONTACT,
    OP_LOAD_INVERTED_CONTACT,
    OP_LOAD_WORD_BIT,
    OP_LOAD_INVERTED_WORD_BIT,
    OP_PARALLEL_CONTACT,
    OP_PARALLEL_INVERTED_CONTACT,
    OP_PARALLEL_WORD_BIT,
    OP_PARALLEL_INVERTED_WORD_BIT,
    OP_SERIES_CONTACT,
    OP_SERIES_INVERTED_CONTACT,
    OP_SERIES_WORD_BIT,
    OP_SERIES_INVERTED_WORD_BIT,
    OP_SERIES_BRANCH_COMBINE,
    OP_PARALLEL_BRANCH_COMBINE,
    OP_OUT
  } opcode_t;

  // One instruction: opcode, point or word address, BCD bit index
  typedef struct packed {
    opcode_t op;
    logic [ADDR_W-1:0] addr;
    logic [BCD_W-1:0] bit_bcd;
  } instr_t;

  // Error flags reported with each rejected instruction
  typedef struct packed {
    logic overflow;
    logic underflow;
    logic bad_bit;
  } fault_t;

endpackage : ladder_pkg

// File: verilog/contact_fetch.sv
`timescale 1ns/1ns
// ************************************************************
// Contact operand selection
// ************************************************************
module contact_fetch (
  input wire logic word_mode,
  input wire logic point_state,
  input wire logic [ladder_pkg::WORD_W-1:0] word_data,
  input wire logic [ladder_pkg::BCD_W-1:0] bit_bcd,
  input wire logic invert,
  output logic contact,
  output logic bit_bad
);

  // BCD digits to a binary index; any digit over nine or value over 15 is bad
  wire logic [3:0] units = bit_bcd[3:0];
  wire logic [3:0] tens = bit_bcd[7:4];
  wire logic digit_bad = (units >= ladder_pkg::BCD_TEN) || (tens > 4'h1);
  wire logic [ladder_pkg::BIT_W-1:0] bit_idx = (tens == 4'h1) ? 4'(units + 4'hA) : units;
  wire logic range_bad = (tens == 4'h1) && (units > 4'h5);
  wire logic sel_bit = word_data[bit_idx];
  wire logic raw = word_mode ? sel_bit : point_state;

  // Inverted variants act as a normally closed contact
  assign contact = raw ^ invert;
  assign bit_bad = word_mode && (digit_bad || range_bad);

endmodule : contact_fetch

// File: sim/lbe_checker_assertions.sv
`timescale 1ns/1ns
// ****
// Stack checks
// ****
module lbe_checker (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic scan_start,
  input wire logic instr_valid,
  input wire ladder_pkg::instr_t instr,
  input wire logic point_state,
  input wire logic out_we,
  input wire logic out_value,
  input wire logic fault_valid,
  input wire logic [3:0] stack_depth,
  input wire logic rung_result
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // Opcodes: 1-4 load, 5-8 parallel, 9-12 series, 13-14 merge, 15 out
  wire logic [3:0] op = instr.op;
  wire logic go = instr_valid && !scan_start;
  wire logic ld = go && op > 4'h0 && op < 4'h5;
  wire logic some = stack_depth != 4'h0;
  // Word-bit loads with a bad index are refused and must not push
  wire logic [3:0] u = instr.bit_bcd[3:0];
  wire logic [3:0] t = instr.bit_bcd[7:4];
  wire logic bcd_ok = op < 4'h3 || (u < 4'hA && (t == 4'h0 || (t == 4'h1 && u < 4'h6)));
  sequence push_s; ld && bcd_ok && stack_depth < 4'h8; endsequence
  sequence full_s; ld && stack_depth == 4'h8; endsequence
  a_load_push: assert property (push_s |=> stack_depth == $past(stack_depth) + 4'h1)
    else $error("load did not push");
  a_full_refused: assert property (full_s |=> fault_valid && stack_depth == 4'h8)
    else $error("overflow not refused");
  a_load_plain: assert property (go && op == 4'h1 && stack_depth < 4'h8
    |=> rung_result == $past(point_state)) else $error("load value wrong");
  a_load_inv: assert property (go && op == 4'h2 && stack_depth < 4'h8
    |=> rung_result == !$past(point_state)) else $error("inverted load wrong");
  a_series_plain: assert property (go && op == 4'h9 && some
    |=> rung_result == ($past(rung_result) & $past(point_state))) else $error("series wrong");
  a_par_inv: assert property (go && op == 4'h6 && some
    |=> rung_result == ($past(rung_result) | !$past(point_state))) else $error("parallel wrong");
  a_merge_pop: assert property (go && op > 4'hC && op < 4'hF && stack_depth > 4'h1
    |=> stack_depth == $past(stack_depth) - 4'h1) else $error("merge depth wrong");
  a_out_write: assert property (go && op == 4'hF && some
    |=> out_we && out_value == $past(rung_result)) else $error("output write wrong");
endmodule : lbe_checker

bind ladder_boolean_evaluator lbe_checker u_chk (.clk_sys, .reset_n, .scan_start, .instr_valid,
  .instr, .point_state, .out_we, .out_value, .fault_valid, .stack_depth, .rung_result);

// File: sim/ladder_boolean_evaluator_tb_top.sv
`timescale 1ns/1ns
// ****
// Bench
// ****
module ladder_boolean_evaluator_tb_top;
  // Fault, write, held output, depth and top of stack
  typedef struct packed {logic f; logic w; logic v; logic [11:0] a; logic [3:0] d; logic r;
    logic m; logic [3:0] b; logic [2:0] x;} note_t;
  logic clk_sys = 1'h0, reset_n = 1'h0, scan_start = 1'h0, instr_valid = 1'h0, point_state = 1'h0;
  logic [15:0] word_data = 16'h0000, rnd = 16'h8B7B;
  ladder_pkg::instr_t instr = 24'h000000;
  logic out_we, out_word_mode, out_value, fault_valid, rung_result, ev = 1'h0;
  logic instr_ready, em = 1'h0;
  logic [3:0] eb = 4'h0;
  ladder_pkg::instr_t operand_req;
  ladder_pkg::fault_t fault;
  logic [11:0] out_addr, ea = 12'h000;
  logic [3:0] out_bit, stack_depth;
  logic [7:0] stk = 8'h00;
  int d = 0, mismatches = 0, check_count = 0;
  note_t q [$];
  note_t n;
  ladder_boolean_evaluator dut (.clk_sys, .reset_n, .scan_start, .instr_valid, .instr,
    .instr_ready, .operand_req, .point_state, .word_data, .out_we, .out_addr, .out_word_mode,
    .out_bit, .out_value, .fault_valid, .fault, .stack_depth, .rung_result);
  // 100 MHz clock
  always #5 clk_sys = ~clk_sys;
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nx
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic finish_test;
    if (mismatches == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test
  // Drive one instruction and note its effect; few addresses so outputs repeat targets
  task automatic step(input logic [3:0] op, input logic [7:0] b, input logic ss);
    logic [1:0] k;
    logic [2:0] x;
    logic c, bad, f, w;
    int bin;
    k = 2'(op - 4'h1);
    // Outputs keep their bit index so bit writes are exercised too
    if (op != 4'hF && (!k[1] || op > 4'hC || op == 4'h0)) b = 8'h00;
    bin = b[7:4] * 10 + b[3:0];
    bad = b[3:0] > 4'h9 || b[7:4] > 4'h1 || bin > 15;
    @(negedge clk_sys);
    rnd = nx(rnd);
    scan_start = ss;
    instr_valid = 1'h1;
    instr = {op, 8'h00, rnd[3:0], b};
    point_state = rnd[15];
    word_data = {rnd[7:0], rnd[15:8]};
    c = (k[1] ? word_data[bin[3:0]] : point_state) ^ k[0];
    // Expected flags: overflow, underflow, bad bit index
    x = {2'h0, k[1] && bad};
    w = 1'h0;
    if (ss) begin
      d = 0;
      stk = 8'h00;
      x = 3'h0;
    end else if (op > 4'h0 && op < 4'h5) begin
      x[2] = d == 8;
      if (x == 3'h0) stk = {stk[6:0], c};
      if (x == 3'h0) d++;
    end else if (op > 4'h4 && op < 4'hD) begin
      x[1] = d == 0;
      if (x == 3'h0) stk[0] = op < 4'h9 ? stk[0] | c : stk[0] & c;
    end else if (op > 4'hC && op < 4'hF) begin
      x = {1'h0, d < 2, 1'h0};
      if (x == 3'h0) stk = {1'h0, stk[7:2], op == 4'hD ? &stk[1:0] : |stk[1:0]};
      if (x == 3'h0) d--;
    end else if (op == 4'hF) begin
      x = {1'h0, d == 0, 1'h0};
      w = x == 3'h0;
      if (w) ev = stk[0];
      if (w) ea = instr.addr;
      if (w) em = b != 8'h00;
      if (w) eb = 4'(bin);
    end
    f = |x;
    q.push_back({f, w, ev, ea, 4'(d), stk[0], em, eb, x});
  endtask : step
  // Results land on the rising edge that takes the instruction and are checked 1 ns later
  always @(posedge clk_sys) begin
    #1;
    if (q.size() > 0) begin
      n = q.pop_front();
      chk("depth", 32'(stack_depth), 32'(n.d));
      chk("result", 32'(rung_result), 32'(n.r));
      chk("fault", 32'(fault_valid), 32'(n.f));
      chk("flags", n.f ? 32'(fault) : 32'h00000000, 32'(n.x));
      chk("out", 32'({out_we, out_word_mode, out_bit, out_value, out_addr}),
        32'({n.w, n.m, n.b, n.v, n.a}));
      chk("request", 32'({instr_ready, operand_req}), 32'({1'h1, instr}));
    end
  end
  // Directed corners first, then a random program
  initial begin
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    reset_n = 1'h1;
    for (int i = 0; i < 9; i++) step(4'(1 + i % 4), 8'h15, 1'h0);
    for (int i = 0; i < 8; i++) step(4'(13 + i % 2), 8'h00, 1'h0);
    for (int i = 5; i < 16; i++) step(4'(i), 8'h09, 1'h0);
    step(4'h3, 8'h0A, 1'h0);
    step(4'h3, 8'h20, 1'h0);
    step(4'h3, 8'h16, 1'h0);
    step(4'hF, 8'h00, 1'h1);
    step(4'hF, 8'h00, 1'h0);
    step(4'h5, 8'h00, 1'h0);
    step(4'h1, 8'h00, 1'h0);
    step(4'hF, 8'h12, 1'h0);
    for (int i = 0; i < 600; i++) step(rnd[3:0], {3'h0, rnd[8:4]}, rnd[15:12] == 4'h0);
    @(negedge clk_sys);
    instr_valid = 1'h0;
    repeat (3) @(posedge clk_sys);
    finish_test();
  end
  // Watchdog well beyond the expected run
  initial begin
    #100000;
    mismatches++;
    finish_test();
  end
endmodule : ladder_boolean_evaluator_tb_top
